//--- logic/mfs_pkg.sv
package mfs_pkg;

  // ************************************************************
  // bus geometry and register offsets
  // ************************************************************
  localparam int          ADDR_W        = 8;      // byte address width
  localparam int          DATA_W        = 32;     // register data width
  localparam logic [7:0]  OFS_HASH_LOW  = 8'h00;  // hash filter bits 31:0
  localparam logic [7:0]  OFS_HASH_HIGH = 8'h04;  // hash filter bits 63:32
  localparam logic [7:0]  OFS_UNI_BASE  = 8'h08;  // unicast pairs, low then high
  localparam logic [7:0]  UNI_STRIDE    = 8'h08;  // bytes per unicast pair
  localparam logic [7:0]  UNI_HI_OFS    = 8'h04;  // high word inside a pair
  localparam logic [7:0]  OFS_CNT_BASE  = 8'h40;  // first statistics counter
  localparam logic [7:0]  WORD_BYTES    = 8'h04;  // one register per word

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int          NUM_UNI   = 4;          // unicast station addresses
  localparam int          UNI_W     = 48;         // station address width
  localparam int          UNI_HI_W  = 16;         // address bits kept in high word
  localparam int          HASH_W    = 64;         // hash filter width
  localparam int          NUM_CNT   = 18;         // statistics counters
  localparam int          CNT_W     = 24;         // widest counter
  localparam int          IDX_W     = 5;          // counter index width

  // counter indexes, in address order
  localparam int CNT_TX_OK  = 0;
  localparam int CNT_SCOL   = 1;
  localparam int CNT_MCOL   = 2;
  localparam int CNT_RX_OK  = 3;
  localparam int CNT_FCS    = 4;
  localparam int CNT_ALIGN  = 5;
  localparam int CNT_DEFER  = 6;
  localparam int CNT_LCOL   = 7;
  localparam int CNT_COLLISION_IN_PIN   = 8;
  localparam int CNT_UNDER  = 9;
  localparam int CNT_CSE    = 10;
  localparam int CNT_DISC   = 11;
  localparam int CNT_ROVR   = 12;
  localparam int CNT_CODE   = 13;
  localparam int CNT_LONG   = 14;
  localparam int CNT_JABB   = 15;
  localparam int CNT_SHORT  = 16;
  localparam int CNT_SQE    = 17;

  localparam logic [CNT_W-1:0] MAX24 = 24'hFFFFFF;  // 24-bit all ones
  localparam logic [CNT_W-1:0] MAX16 = 24'h00FFFF;  // 16-bit all ones
  localparam logic [CNT_W-1:0] MAX8  = 24'h0000FF;  // 8-bit all ones

  // ************************************************************
  // frame limits and timing
  // ************************************************************
  localparam logic [15:0] LEN_MIN       = 16'h0040;  // 64 bytes
  localparam logic [15:0] LEN_MAX       = 16'h05EE;  // 1518 bytes
  localparam logic [15:0] LEN_MIN_MCOL  = 16'h003E;  // 62 bytes
  localparam logic [4:0]  COL_ONE       = 5'h01;
  localparam logic [4:0]  COL_TWO       = 5'h02;
  localparam logic [4:0]  COL_FIFTEEN   = 5'h0F;
  localparam logic [4:0]  COL_EXCESS    = 5'h10;     // 16 collisions
  localparam int          SLOT_BITS     = 512;
  localparam int          BIT_TIME_NS   = 100;       // 10 Mb/s bit time
  localparam int          CLK_PERIOD_NS = 4;         // 250 MHz core clock
  localparam int          SLOT_TIME_NS  = SLOT_BITS * BIT_TIME_NS;
  localparam int          SLOT_CYC      = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int          TMR_W         = 20;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic              wr;     // write strobe
    logic              rd;     // read strobe
    logic [ADDR_W-1:0] addr;   // byte address
    logic [DATA_W-1:0] wdata;  // write data
  } mfs_bus_req_s;

  typedef struct packed {
    logic        done;          // one-cycle end-of-frame report
    logic        underrun;      // dma underrun, frame abandoned
    logic        carrier_loss;
    logic        late_col;      // collision after slot time
    logic        deferred;      // first attempt deferred
    logic        no_carrier;    // carrier absent one slot in
    logic        half_duplex;
    logic [4:0]  col_count;     // collisions seen, 16 = abandoned
    logic [15:0] length;        // bytes
  } mfs_tx_evt_s;

  typedef struct packed {
    logic        done;          // one-cycle end-of-frame report
    logic        addr_match;
    logic        fcs_bad;       // crc over whole bytes bad
    logic        dribble;       // not a whole number of bytes
    logic        code_err;      // rx error seen during frame
    logic        no_buffer;
    logic        overrun;
    logic [15:0] length;
  } mfs_rx_evt_s;

  typedef enum logic { SQE_IDLE, SQE_WATCH } mfs_sqe_e;

endpackage

//--- logic/mfs_addr_stats.sv
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module mfs_addr_stats
  import mfs_pkg::*;
#(
  parameter int SQE_WINDOW_CYC = SLOT_CYC  // shorten for simulation
)(
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire mfs_bus_req_s                bus_req,
  output logic [DATA_W-1:0]                rd_data_q,
  input  wire mfs_tx_evt_s                 tx_evt,
  input  wire mfs_rx_evt_s                 rx_evt,
  input  wire logic                        transmit_enable_pin,
  input  wire logic                        collision_in_pin,
  output logic [HASH_W-1:0]                hash_filter_q,
  output logic [NUM_UNI-1:0][UNI_W-1:0]    uni_addr_q
);

  // ************************************************************
  // helper functions
  // ************************************************************
  // saturation ceiling of each counter
  function automatic logic [CNT_W-1:0] cnt_max(input int idx);
    logic [CNT_W-1:0] m;
    m = MAX8;
    if (idx == CNT_TX_OK || idx == CNT_RX_OK)
      m = MAX24;
    else if (idx == CNT_SCOL || idx == CNT_MCOL || idx == CNT_DEFER || idx == CNT_DISC)
      m = MAX16;
    return m;
  endfunction

  // inclusive length window
  function automatic logic len_in(input logic [15:0] len, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (len >= lo) && (len <= hi);
  endfunction

  // byte offset of a unicast word
  function automatic logic [ADDR_W-1:0] uni_ofs(input int n, input logic hi);
    logic [ADDR_W-1:0] o;
    o = OFS_UNI_BASE + UNI_STRIDE * ADDR_W'(n);
    if (hi)
      o = o + UNI_HI_OFS;
    return o;
  endfunction

  // ************************************************************
  // address decode
  // ************************************************************
  wire  logic [NUM_UNI-1:0] uni_lo_hit;   // low word selected, one assign per bit
  wire  logic [NUM_UNI-1:0] uni_hi_hit;   // high word selected, one assign per bit
  wire  logic         hash_lo_hit = (bus_req.addr == OFS_HASH_LOW);
  wire  logic         hash_hi_hit = (bus_req.addr == OFS_HASH_HIGH);
  wire  logic [ADDR_W-1:0] cnt_rel = bus_req.addr - OFS_CNT_BASE;
  wire  logic         cnt_hit = (bus_req.addr >= OFS_CNT_BASE) && (bus_req.addr[1:0] == 2'h0)
                                && (cnt_rel < WORD_BYTES * ADDR_W'(NUM_CNT));
  wire  logic [IDX_W-1:0] cnt_idx = cnt_rel[IDX_W+1:2];  // word index of counter
  wire  logic         cnt_rd = bus_req.rd && cnt_hit;     // read-to-clear strobe

  genvar g;
  generate
    for (g = 0; g < NUM_UNI; g++)
    begin : g_uni_dec
      assign uni_lo_hit[g] = (bus_req.addr == uni_ofs(g, 1'b0));
      assign uni_hi_hit[g] = (bus_req.addr == uni_ofs(g, 1'b1));
    end
  endgenerate

  // ************************************************************
  // filter registers
  // ************************************************************
  // full-width hash words; both halves always writable
  // strobes never overlap, so the two branches never compete
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      hash_filter_q <= '0;
    else if (bus_req.wr && hash_hi_hit)
      hash_filter_q[HASH_W-1:DATA_W] <= bus_req.wdata;
    else if (bus_req.wr && hash_lo_hit)
      hash_filter_q[DATA_W-1:0] <= bus_req.wdata;
  end

  // station addresses; upper half of the high word is dropped on write
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      uni_addr_q <= '0;
    else
    begin
      for (int n = 0; n < NUM_UNI; n++)
      begin
        if (bus_req.wr && uni_hi_hit[n])
          uni_addr_q[n][UNI_W-1:DATA_W] <= bus_req.wdata[UNI_HI_W-1:0];
        if (bus_req.wr && uni_lo_hit[n])
          uni_addr_q[n][DATA_W-1:0] <= bus_req.wdata;
      end
    end
  end

  // ************************************************************
  // transmit event classification
  // ************************************************************
  // an underrun frame feeds no counter but its own
  wire logic tx_clean = tx_evt.done && !tx_evt.underrun;
  wire logic tx_nocl  = tx_clean && !tx_evt.carrier_loss;
  wire logic tx_sent  = tx_evt.col_count != COL_EXCESS;
  wire logic [NUM_CNT-1:0] inc_v;  // per-counter increment request, one assign per bit

  assign inc_v[CNT_TX_OK] = tx_clean && tx_sent;
  assign inc_v[CNT_SCOL]  = tx_nocl && (tx_evt.col_count == COL_ONE);
  assign inc_v[CNT_MCOL]  = tx_nocl && (tx_evt.col_count >= COL_TWO)
                            && (tx_evt.col_count <= COL_FIFTEEN)
                            && len_in(tx_evt.length, LEN_MIN_MCOL, LEN_MAX);
  assign inc_v[CNT_DEFER] = tx_clean && tx_evt.deferred
                            && (tx_evt.col_count == '0);
  // late collision also sits in col_count, so it lands in scol or mcol too
  assign inc_v[CNT_LCOL]  = tx_nocl && tx_evt.late_col;
  assign inc_v[CNT_COLLISION_IN_PIN]  = tx_nocl && !tx_sent
                            && len_in(tx_evt.length, LEN_MIN, LEN_MAX);
  assign inc_v[CNT_UNDER] = tx_evt.done && tx_evt.underrun;
  assign inc_v[CNT_CSE]   = tx_clean && tx_evt.half_duplex && tx_evt.no_carrier
                            && tx_sent;

  // ************************************************************
  // receive event classification
  // ************************************************************
  wire logic rx_code  = rx_evt.done && rx_evt.addr_match && rx_evt.code_err;
  wire logic rx_live  = rx_evt.done && !rx_code;  // address-matched rx error frame blocks the rest
  wire logic rx_match = rx_live && rx_evt.addr_match;
  wire logic rx_range = len_in(rx_evt.length, LEN_MIN, LEN_MAX);
  wire logic rx_dirty = rx_evt.fcs_bad || rx_evt.code_err;  // crc, alignment or code
  wire logic rx_long  = rx_evt.length > LEN_MAX;

  assign inc_v[CNT_RX_OK] = rx_match && rx_range && !rx_dirty;
  assign inc_v[CNT_FCS]   = rx_match && rx_range && !rx_evt.dribble
                            && rx_evt.fcs_bad;
  assign inc_v[CNT_ALIGN] = rx_match && rx_range && rx_evt.dribble
                            && rx_evt.fcs_bad;
  assign inc_v[CNT_DISC]  = rx_match && rx_evt.no_buffer;
  assign inc_v[CNT_ROVR]  = rx_match && rx_evt.overrun;
  assign inc_v[CNT_CODE]  = rx_code;
  assign inc_v[CNT_LONG]  = rx_live && rx_long && !rx_dirty;
  assign inc_v[CNT_JABB]  = rx_live && rx_long && rx_dirty;
  assign inc_v[CNT_SHORT] = rx_live && (rx_evt.length < LEN_MIN) && !rx_dirty;

  // ************************************************************
  // heartbeat watch after transmit enable falls
  // ************************************************************
  mfs_sqe_e         sqe_q;      // watching for collision
  mfs_sqe_e         sqe_d;
  logic [TMR_W-1:0] tmr_q;      // cycles since transmit end
  logic [TMR_W-1:0] tmr_d;
  logic             txen_q;     // previous transmit enable
  wire  logic       tmr_end  = tmr_q == TMR_W'(SQE_WINDOW_CYC - 1);
  wire  logic       txen_off = txen_q && !transmit_enable_pin;

  // a new frame starting inside the window cancels the watch silently
  always_comb
  begin
    sqe_d = sqe_q;
    tmr_d = tmr_q;
    case (sqe_q)
      SQE_IDLE:
      begin
        tmr_d = '0;
        if (txen_off)
          sqe_d = SQE_WATCH;
      end
      SQE_WATCH:
      begin
        tmr_d = tmr_q + TMR_W'(1);
        if (collision_in_pin || transmit_enable_pin || tmr_end)
          sqe_d = SQE_IDLE;
      end
      default:
        sqe_d = SQE_IDLE;
    endcase
  end

  assign inc_v[CNT_SQE] = (sqe_q == SQE_WATCH) && tmr_end
                          && !collision_in_pin && !transmit_enable_pin;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sqe_q  <= SQE_IDLE;
      tmr_q  <= '0;
      txen_q <= 1'b0;
    end
    else
    begin
      sqe_q  <= sqe_d;
      tmr_q  <= tmr_d;
      txen_q <= transmit_enable_pin;
    end
  end

  // ************************************************************
  // statistics counters
  // ************************************************************
  logic [CNT_W-1:0] cnt_q [NUM_CNT];  // live counts
  logic [CNT_W-1:0] cnt_d [NUM_CNT];

  // read clears, but an event in the read cycle survives as a count of one
  always_comb
  begin
    for (int i = 0; i < NUM_CNT; i++)
    begin
      cnt_d[i] = cnt_q[i];
      if (cnt_rd && (cnt_idx == IDX_W'(i)))
        cnt_d[i] = inc_v[i] ? CNT_W'(1) : '0;
      else if (inc_v[i] && (cnt_q[i] != cnt_max(i)))
        cnt_d[i] = cnt_q[i] + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      for (int i = 0; i < NUM_CNT; i++)
        cnt_q[i] <= '0;
    else
      for (int i = 0; i < NUM_CNT; i++)
        cnt_q[i] <= cnt_d[i];
  end

  // ************************************************************
  // read data path
  // ************************************************************
  logic [DATA_W-1:0] rd_mux;   // selected word, zero when unmapped
  wire  logic [CNT_W-1:0] cnt_sel = cnt_hit ? cnt_q[cnt_idx] : '0;

  always_comb
  begin
    rd_mux = '0;
    if (hash_lo_hit)
      rd_mux = hash_filter_q[DATA_W-1:0];
    else if (hash_hi_hit)
      rd_mux = hash_filter_q[HASH_W-1:DATA_W];
    else if (cnt_hit)
      rd_mux = DATA_W'(cnt_sel);
    else
      for (int n = 0; n < NUM_UNI; n++)
      begin
        if (uni_lo_hit[n])
          rd_mux = uni_addr_q[n][DATA_W-1:0];
        if (uni_hi_hit[n])
          rd_mux = {16'h0000, uni_addr_q[n][UNI_W-1:DATA_W]};
      end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rd_data_q <= '0;
    else if (bus_req.rd)
      rd_data_q <= rd_mux;
    else
      rd_data_q <= '0;
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence seq_cnt_read;
    bus_req.rd && cnt_hit;
  endsequence

  sequence seq_hi_write;
    bus_req.wr && hash_hi_hit;
  endsequence

  // late collision on a single-collision frame
  sequence seq_late_single;
    inc_v[CNT_LCOL] && (tx_evt.col_count == COL_ONE);
  endsequence

  // back-to-back write and read must see the new word
  chk_hash_high_rw: assert property (@(posedge core_clk) disable iff (!resetn)
    seq_hi_write ##1 (bus_req.rd && hash_hi_hit && !bus_req.wr)
    |=> rd_data_q == $past(hash_filter_q[HASH_W-1:DATA_W]))
    else $error("hash high readback wrong");

  chk_hash_low_rw: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_req.wr && hash_lo_hit |=> hash_filter_q[DATA_W-1:0] == $past(bus_req.wdata)
                                  && $stable(hash_filter_q[HASH_W-1:DATA_W]))
    else $error("hash low write wrong");

  chk_uni_split: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_req.wr && uni_hi_hit[0]
    |=> uni_addr_q[0][UNI_W-1:DATA_W] == $past(bus_req.wdata[UNI_HI_W-1:0])
        && $stable(uni_addr_q[0][DATA_W-1:0]))
    else $error("unicast high write wrong");

  chk_uni_top_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    bus_req.rd && (uni_hi_hit != '0) |=> rd_data_q[31:16] == 16'h0000)
    else $error("unicast high upper bits not zero");

  chk_read_returns: assert property (@(posedge core_clk) disable iff (!resetn)
    seq_cnt_read |=> rd_data_q == DATA_W'($past(cnt_sel)))
    else $error("counter read value wrong");

  // read data must not linger, or software would see a stale count twice
  chk_rd_idle_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    !bus_req.rd |=> rd_data_q == '0)
    else $error("read data stood past its cycle");

  chk_read_clears: assert property (@(posedge core_clk) disable iff (!resetn)
    seq_cnt_read and (cnt_idx == IDX_W'(CNT_FCS)) and !inc_v[CNT_FCS]
    |=> cnt_q[CNT_FCS] == '0)
    else $error("counter not cleared by read");

  // an 8-bit counter is the one a short run can really fill
  chk_sat_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    cnt_q[CNT_UNDER] == MAX8 && !(cnt_rd && cnt_idx == IDX_W'(CNT_UNDER))
    |=> cnt_q[CNT_UNDER] == MAX8)
    else $error("counter wrapped past maximum");

  chk_tx_ok_step: assert property (@(posedge core_clk) disable iff (!resetn)
    tx_evt.done && !tx_evt.underrun && tx_sent && !cnt_rd && cnt_q[CNT_TX_OK] != MAX24
    |=> cnt_q[CNT_TX_OK] == $past(cnt_q[CNT_TX_OK]) + CNT_W'(1))
    else $error("tx ok counter did not step");

  chk_underrun_alone: assert property (@(posedge core_clk) disable iff (!resetn)
    inc_v[CNT_UNDER] |-> !inc_v[CNT_TX_OK] && !inc_v[CNT_SCOL] && !inc_v[CNT_MCOL]
                         && !inc_v[CNT_LCOL] && !inc_v[CNT_COLLISION_IN_PIN] && !inc_v[CNT_CSE]
                         && !inc_v[CNT_DEFER])
    else $error("underrun frame counted elsewhere");

  chk_late_twice: assert property (@(posedge core_clk) disable iff (!resetn)
    seq_late_single |-> inc_v[CNT_SCOL])
    else $error("late collision not also counted as collision");

  chk_code_alone: assert property (@(posedge core_clk) disable iff (!resetn)
    inc_v[CNT_CODE] |-> !inc_v[CNT_RX_OK] && !inc_v[CNT_FCS] && !inc_v[CNT_LONG]
                        && !inc_v[CNT_JABB] && !inc_v[CNT_DISC] && !inc_v[CNT_SHORT]
                        && !inc_v[CNT_ALIGN] && !inc_v[CNT_ROVR])
    else $error("rx error frame counted elsewhere");

  chk_sqe_cancel: assert property (@(posedge core_clk) disable iff (!resetn)
    sqe_q == SQE_WATCH && collision_in_pin |-> !inc_v[CNT_SQE] ##1 sqe_q == SQE_IDLE)
    else $error("collision did not end heartbeat watch");

  // a quiet window that runs out must land in the counter
  chk_sqe_step: assert property (@(posedge core_clk) disable iff (!resetn)
    sqe_q == SQE_WATCH && tmr_end && !collision_in_pin && !transmit_enable_pin
    && !cnt_rd && cnt_q[CNT_SQE] != MAX8
    |=> cnt_q[CNT_SQE] == $past(cnt_q[CNT_SQE]) + CNT_W'(1))
    else $error("heartbeat counter did not step");

endmodule

//--- dv/mfs_engine_model.sv
`timescale 1ns/100ps
// ****************************************
// mac engine model: frame reports and pins
// ****************************************
module mfs_engine_model
  import mfs_pkg::*;
(
  input  wire logic   core_clk,
  output mfs_tx_evt_s tx_evt,
  output mfs_rx_evt_s rx_evt,
  output logic        txen,
  output logic        col
);
  // quiet lines at time zero
  initial
  begin
    tx_evt = '0;
    rx_evt = '0;
    txen   = 1'b0;
    col    = 1'b0;
  end

  // one-cycle report; attributes scrambled after it, they are only valid with done
  task send_tx(input mfs_tx_evt_s ev);
    @(posedge core_clk) tx_evt <= ev;
    @(posedge core_clk) tx_evt <= {1'b0, ~ev[26:0]};
  endtask

  task send_rx(input mfs_rx_evt_s ev);
    @(posedge core_clk) rx_evt <= ev;
    @(posedge core_clk) rx_evt <= {1'b0, ~ev[21:0]};
  endtask

  // short transmission, then an optional collision inside the quiet window
  task sqe_burst(input logic hit);
    @(posedge core_clk) txen <= 1'b1;
    repeat (3) @(posedge core_clk);
    txen <= 1'b0;
    repeat (3) @(posedge core_clk);
    col <= hit;
    @(posedge core_clk) col <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask
endmodule

//--- dv/mfs_addr_stats_bench.sv
`timescale 1ns/100ps
module mfs_addr_stats_bench;
  import mfs_pkg::*;

  // ****************************************
  // clock, reset and wiring
  // ****************************************
  logic                          core_clk = 1'b0;  // 4 ns period
  logic                          resetn   = 1'b0;  // held for 8 cycles
  mfs_bus_req_s                  bus_req  = '0;    // register bus request
  logic [DATA_W-1:0]             rd_data_q;        // read answer
  mfs_tx_evt_s                   tx_evt;           // engine reports
  mfs_rx_evt_s                   rx_evt;
  logic                          txen;
  logic                          col;
  logic [HASH_W-1:0]             hash_filter_q;
  logic [NUM_UNI-1:0][UNI_W-1:0] uni_addr_q;
  logic [DATA_W-1:0]             v;                // last read value
  int                            fail_count = 0;
  int                            n_checks   = 0;
  int                            cyc        = 0;   // timeout counter

  always #2 core_clk = ~core_clk;

  mfs_engine_model u_eng (.core_clk(core_clk), .tx_evt(tx_evt), .rx_evt(rx_evt),
    .txen(txen), .col(col));

  // short quiet window keeps the heartbeat test brief
  mfs_addr_stats #(.SQE_WINDOW_CYC(8)) DUT (.core_clk(core_clk), .resetn(resetn),
    .bus_req(bus_req), .rd_data_q(rd_data_q), .tx_evt(tx_evt), .rx_evt(rx_evt),
    .transmit_enable_pin(txen), .collision_in_pin(col),
    .hash_filter_q(hash_filter_q), .uni_addr_q(uni_addr_q));

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk) bus_req <= '0;
    #1;
  endtask

  // write then read with no gap; the read sees the new word
  task wr_rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk) bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge core_clk) bus_req <= '0;
    #1 v = rd_data_q;
  endtask

  // answer stands only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge core_clk) bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge core_clk) bus_req <= '0;
    #1 v = rd_data_q;
  endtask

  // read every counter, one expected bit each; a read also clears it
  task chk_all(input logic [17:0] mask);
    for (int i = 0; i < NUM_CNT; i++)
    begin
      rd(OFS_CNT_BASE + 8'(i * 4));
      chk("counter", v, {63'h0, mask[i]});
    end
  endtask

  task txc(input logic u, cl, lc, df, nc, hd, input logic [4:0] c,
           input logic [15:0] len, input logic [17:0] mask);
    u_eng.send_tx('{1'b1, u, cl, lc, df, nc, hd, c, len});
    chk_all(mask);
  endtask

  task rxc(input logic m, f, dr, ce, nb, ov, input logic [15:0] len,
           input logic [17:0] mask);
    u_eng.send_rx('{1'b1, m, f, dr, ce, nb, ov, len});
    chk_all(mask);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // filter and station registers, reserved bits and an unmapped place
  task t_regs;
    wr(OFS_HASH_LOW, 32'hA5A50F0F);
    wr(OFS_HASH_HIGH, 32'h12345678);
    chk("hash out", hash_filter_q, 64'h12345678A5A50F0F);
    rd(OFS_HASH_HIGH);
    chk("hash high", v, 64'h12345678);
    rd(OFS_HASH_LOW);
    chk("hash low", v, 64'hA5A50F0F);
    wr_rd(OFS_HASH_HIGH, 32'h87654321);
    chk("hash back", v, 64'h87654321);
    for (int n = 0; n < NUM_UNI; n++)
    begin
      wr(8'h08 + 8'(n * 8), 32'hC0DE0000 + n);
      wr(8'h0C + 8'(n * 8), 32'hFFFFAB00 + n);
      rd(8'h0C + 8'(n * 8));
      chk("uni high", v, 64'h0000AB00 + n);
      chk("uni out", uni_addr_q[n], {16'hAB00 + 16'(n), 32'hC0DE0000 + n});
    end
    @(posedge core_clk) #1 chk("read gap", rd_data_q, 64'h0);
    wr(8'h88, 32'hFFFFFFFF);
    rd(8'h88);
    chk("unmapped", v, 64'h0);
    $display("test regs done");
  endtask

  // every transmit outcome, with boundary lengths and collision counts
  task t_tx;
    txc(0, 0, 0, 0, 0, 0, 5'h00, 16'h0064, 18'h00001);
    txc(0, 0, 0, 0, 0, 0, 5'h01, 16'h0064, 18'h00003);
    txc(0, 0, 0, 0, 0, 0, 5'h02, 16'h003E, 18'h00005);
    txc(0, 0, 0, 0, 0, 0, 5'h0F, 16'h05EE, 18'h00005);
    txc(0, 0, 0, 0, 0, 0, 5'h10, 16'h0040, 18'h00100);
    txc(1, 0, 0, 1, 0, 0, 5'h01, 16'h0064, 18'h00200);
    txc(0, 0, 0, 1, 0, 0, 5'h00, 16'h0064, 18'h00041);
    txc(0, 0, 1, 0, 0, 0, 5'h01, 16'h0064, 18'h00083);
    txc(0, 0, 0, 0, 1, 1, 5'h00, 16'h0064, 18'h00401);
    txc(0, 1, 0, 0, 0, 0, 5'h01, 16'h0064, 18'h00001);
    $display("test tx done");
  endtask

  // every receive outcome, address match and length limits
  task t_rx;
    rxc(1, 0, 0, 0, 0, 0, 16'h0040, 18'h00008);
    rxc(1, 1, 0, 0, 0, 0, 16'h05EE, 18'h00010);
    rxc(1, 1, 1, 0, 0, 0, 16'h0064, 18'h00020);
    rxc(1, 0, 0, 0, 1, 0, 16'h0064, 18'h00808);
    rxc(1, 0, 0, 0, 0, 1, 16'h0064, 18'h01008);
    rxc(1, 1, 0, 1, 0, 0, 16'h0064, 18'h02000);
    rxc(0, 0, 0, 0, 0, 0, 16'h05EF, 18'h04000);
    rxc(0, 1, 0, 0, 0, 0, 16'h07D0, 18'h08000);
    rxc(0, 0, 0, 0, 0, 0, 16'h003F, 18'h10000);
    rxc(0, 0, 0, 0, 0, 0, 16'h0064, 18'h00000);
    $display("test rx done");
  endtask

  // overfill an 8-bit counter; software then reads it before more is lost
  task t_sat;
    repeat (300) u_eng.send_tx('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0064});
    rd(8'h64);
    chk("saturated", v, 64'hFF);
    rd(8'h64);
    chk("cleared", v, 64'h0);
    $display("test sat done");
  endtask

  // quiet window after transmit: no collision counts, collision does not
  task t_sqe;
    u_eng.sqe_burst(1'b0);
    rd(8'h84);
    chk("sqe miss", v, 64'h1);
    u_eng.sqe_burst(1'b1);
    rd(8'h84);
    chk("sqe seen", v, 64'h0);
    $display("test sqe done");
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, well above the roughly 1500 cycles the tests need
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_sat();
    t_sqe();
    stop_test();
  end
endmodule
